//--- verilog/adc_ctrl_pkg.sv
// Constants, register map and state type of the converter control block
package adc_ctrl_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] CTRL0_ADDR = 8'h00;
  localparam logic [7:0] CFG1_ADDR  = 8'h04;
  localparam logic [7:0] CFG2_ADDR  = 8'h08;
  localparam logic [7:0] RESH_ADDR  = 8'h0C;
  localparam logic [7:0] RESL_ADDR  = 8'h10;
  localparam logic [7:0] STAT_ADDR  = 8'h14;
  // Field positions
  localparam int ON_BIT   = 0;
  localparam int GO_BIT   = 1;
  localparam int CHS_LSB  = 2;
  localparam int PREF_BIT = 4;
  localparam int NREF_BIT = 5;
  localparam int CS_LSB   = 0;
  localparam int ACQ_LSB  = 3;
  localparam int JUST_BIT = 7;
  localparam int DONE_BIT = 0;
  // Reset values
  localparam logic [3:0] CHS_RST        = 4'h0;
  localparam logic [2:0] CFG2_FIELD_RST = 3'h0;
  localparam logic [3:0] MAP_ANALOG     = 4'h0;
  localparam logic [3:0] MAP_PART_DIG   = 4'h7;
  // Converter geometry
  localparam int         NUM_CHANNELS = 13;
  localparam int         RES_BITS     = 10;
  localparam logic [3:0] CONV_LAST    = 4'hA;
  localparam logic [9:0] TRIAL_MSB    = 10'h200;
  localparam logic [3:0] MAP_FIRST_DIG = 4'h3;
  // Timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int RC_TAD_NS      = 2500;
  localparam int RC_TAD_CYCLES  = RC_TAD_NS / CLK_PERIOD_NS;
  localparam int INSTR_CYCLE_NS = 160;
  localparam int INSTR_CYCLES   =
    (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bus encodings
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE, ST_RC_DELAY, ST_ACQUIRE, ST_CONVERT
  } state_t;
endpackage

//--- verilog/sar_adc_control.sv
// Successive-approximation converter control with an AHB-Lite register slave
//
// Overview of operation
// - Channel field bits 5-2 picks input 0-12
// - Go/done bit high while converting, starts
// - Finish loads result, clears go, sets flag
// - Ten-bit result, one bit per period
// - Bit 5 picks negative reference pin
// - Bit 4 picks positive reference pin
// - Port map resets from strap: 0000/0111
// - Bit 7 selects right or left justify
// - Acquisition code maps to 0-20 periods
// - Clock code picks divider or RC clock
// - RC clock starts after one instruction cycle
// - Sleep conversion only with RC clock
// - Reset clears controls and aborts conversion
// - Result pair has no reset value
// - Programmed acquisition precedes automatic conversion
// - Unimplemented control bits read zero
// - Eleven bit periods per conversion
// - Zero acquisition converts immediately on go with a divider clock
// - Sampling resumes after each conversion
`timescale 1ns/100ps
module sar_adc_control (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic      [1:0]  HRESP,
  // Chip state and comparator
  input  wire logic        SLEEP,
  input  wire logic        PORTB_ANALOG_DEFAULT,
  input  wire logic        COMP_IN,
  // Analog front end controls
  output logic      [12:0] ANALOG_MUX,
  output logic      [12:0] ANALOG_MAP,
  output logic             NEG_REF_SELECT,
  output logic             POS_REF_SELECT,
  output logic             SAMPLE_ENABLE,
  output logic      [9:0]  DAC_CODE,
  output logic             CONVERTER_ON,
  output logic             CONVERSION_DONE_FLAG
);
  adc_ctrl_pkg::state_t state, next_state;
  logic [3:0]  channel_select, port_analog_map, conv_cnt;
  logic [2:0]  acquire_time_select, conv_clock_select, dly_cnt;
  logic [4:0]  acq_left, acq_tads;
  logic [6:0]  tick_cnt, tick_div;
  logic [9:0]  dac;
  logic [7:0]  result_high, result_low, wr_addr, rd_mux;
  logic        converter_on, neg_ref_select, pos_ref_select, result_justify;
  logic        done_flag, strap_done, wr_pend, start, rc_sel, bit_tick;
  logic        finish, comp_level, addr_ok;
  logic        busy;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  assign busy   = (state != adc_ctrl_pkg::ST_IDLE);
  assign rc_sel = (conv_clock_select[1:0] == 2'h3);
  assign addr_ok = HSEL & HREADY & HTRANS[1] & (HADDR[31:8] == 24'h0);

  // Register reads; upper control bits are hard zeros
  always_comb begin
    unique case (HADDR[7:0])
      adc_ctrl_pkg::CTRL0_ADDR: rd_mux = {2'h0, channel_select, busy,
                                          converter_on};
      adc_ctrl_pkg::CFG1_ADDR:  rd_mux = {2'h0, neg_ref_select,
                                          pos_ref_select, port_analog_map};
      adc_ctrl_pkg::CFG2_ADDR:  rd_mux = {result_justify, 1'b0,
                                          acquire_time_select,
                                          conv_clock_select};
      adc_ctrl_pkg::RESH_ADDR:  rd_mux = result_high;
      adc_ctrl_pkg::RESL_ADDR:  rd_mux = result_low;
      adc_ctrl_pkg::STAT_ADDR:  rd_mux = {7'h0, done_flag};
      default:                  rd_mux = 8'h00;
    endcase
  end

  // Bus slave: no wait states, read data prepared in the address phase
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA    <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP     <= adc_ctrl_pkg::HRESP_OKAY;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= adc_ctrl_pkg::HRESP_OKAY;
      wr_pend   <= addr_ok & HWRITE;
      wr_addr   <= HADDR[7:0];
      HRDATA    <= (addr_ok & ~HWRITE) ? {24'h0, rd_mux} : 32'h0;
    end
  end

  // Go only counts with the converter on and nothing in flight
  assign start = wr_pend & (wr_addr == adc_ctrl_pkg::CTRL0_ADDR) &
                 HWDATA[adc_ctrl_pkg::GO_BIT] &
                 HWDATA[adc_ctrl_pkg::ON_BIT] & converter_on & !busy;

  // Control registers; reset returns every field to its reset value
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      converter_on        <= 1'b0;
      channel_select      <= adc_ctrl_pkg::CHS_RST;
      neg_ref_select      <= 1'b0;
      pos_ref_select      <= 1'b0;
      result_justify      <= 1'b0;
      acquire_time_select <= adc_ctrl_pkg::CFG2_FIELD_RST;
      conv_clock_select   <= adc_ctrl_pkg::CFG2_FIELD_RST;
    end else if (wr_pend) begin
      unique case (wr_addr)
        adc_ctrl_pkg::CTRL0_ADDR: begin
          converter_on   <= HWDATA[adc_ctrl_pkg::ON_BIT];
          channel_select <= HWDATA[adc_ctrl_pkg::CHS_LSB +: 4];
        end
        adc_ctrl_pkg::CFG1_ADDR: begin
          neg_ref_select <= HWDATA[adc_ctrl_pkg::NREF_BIT];
          pos_ref_select <= HWDATA[adc_ctrl_pkg::PREF_BIT];
        end
        adc_ctrl_pkg::CFG2_ADDR: begin
          result_justify      <= HWDATA[adc_ctrl_pkg::JUST_BIT];
          acquire_time_select <= HWDATA[adc_ctrl_pkg::ACQ_LSB +: 3];
          conv_clock_select   <= HWDATA[adc_ctrl_pkg::CS_LSB +: 3];
        end
        default: ;
      endcase
    end
  end

  // Port map: constant under reset, strap caught on the first edge after
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      port_analog_map <= adc_ctrl_pkg::MAP_ANALOG;
      strap_done      <= 1'b0;
    end else if (!strap_done) begin
      port_analog_map <= PORTB_ANALOG_DEFAULT ? adc_ctrl_pkg::MAP_ANALOG
                                              : adc_ctrl_pkg::MAP_PART_DIG;
      strap_done      <= 1'b1;
    end else if (wr_pend && wr_addr == adc_ctrl_pkg::CFG1_ADDR) begin
      port_analog_map <= HWDATA[3:0];
    end
  end

  // Acquisition length in bit periods
  always_comb begin
    unique case (acquire_time_select)
      3'h0: acq_tads = 5'd0;
      3'h1: acq_tads = 5'd2;
      3'h2: acq_tads = 5'd4;
      3'h3: acq_tads = 5'd6;
      3'h4: acq_tads = 5'd8;
      3'h5: acq_tads = 5'd12;
      3'h6: acq_tads = 5'd16;
      3'h7: acq_tads = 5'd20;
    endcase
  end

  // Oscillator cycles per bit period; the RC clock is modelled by count
  always_comb begin
    unique case (conv_clock_select)
      3'h0: tick_div = 7'd2;
      3'h1: tick_div = 7'd8;
      3'h2: tick_div = 7'd32;
      3'h4: tick_div = 7'd4;
      3'h5: tick_div = 7'd16;
      3'h6: tick_div = 7'd64;
      default: tick_div = 7'(adc_ctrl_pkg::RC_TAD_CYCLES);
    endcase
  end

  // Bit period generator; a sleeping core stops the oscillator clocks
  assign bit_tick = (state == adc_ctrl_pkg::ST_ACQUIRE ||
                     state == adc_ctrl_pkg::ST_CONVERT) &&
                    (tick_cnt == tick_div - 7'd1) &&
                    !(SLEEP && !rc_sel);
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt <= 7'd0;
    end else if (state == adc_ctrl_pkg::ST_IDLE ||
                 state == adc_ctrl_pkg::ST_RC_DELAY) begin
      tick_cnt <= 7'd0;
    end else if (SLEEP && !rc_sel) begin
      tick_cnt <= tick_cnt;
    end else begin
      tick_cnt <= bit_tick ? 7'd0 : tick_cnt + 7'd1;
    end
  end

  assign finish = (state == adc_ctrl_pkg::ST_CONVERT) && bit_tick &&
                  (conv_cnt == adc_ctrl_pkg::CONV_LAST);

  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      adc_ctrl_pkg::ST_IDLE:
        if (start) begin
          if (rc_sel)
            next_state = adc_ctrl_pkg::ST_RC_DELAY;
          else if (acq_tads != 5'd0)
            next_state = adc_ctrl_pkg::ST_ACQUIRE;
          else
            next_state = adc_ctrl_pkg::ST_CONVERT;
        end
      adc_ctrl_pkg::ST_RC_DELAY:
        if (dly_cnt == 3'd0)
          next_state = (acq_tads != 5'd0) ? adc_ctrl_pkg::ST_ACQUIRE
                                          : adc_ctrl_pkg::ST_CONVERT;
      adc_ctrl_pkg::ST_ACQUIRE:
        if (bit_tick && acq_left == 5'd1)
          next_state = adc_ctrl_pkg::ST_CONVERT;
      adc_ctrl_pkg::ST_CONVERT:
        if (finish)
          next_state = adc_ctrl_pkg::ST_IDLE;
    endcase
    if (!converter_on)
      next_state = adc_ctrl_pkg::ST_IDLE;
  end

  // Sequencer state and its counters
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state    <= adc_ctrl_pkg::ST_IDLE;
      dly_cnt  <= 3'd0;
      acq_left <= 5'd0;
    end else begin
      state <= next_state;
      if (start)
        dly_cnt <= 3'(adc_ctrl_pkg::INSTR_CYCLES - 1);
      else if (dly_cnt != 3'd0)
        dly_cnt <= dly_cnt - 3'd1;
      if (next_state == adc_ctrl_pkg::ST_ACQUIRE &&
          state != adc_ctrl_pkg::ST_ACQUIRE)
        acq_left <= acq_tads;
      else if (bit_tick && acq_left != 5'd0)
        acq_left <= acq_left - 5'd1;
    end
  end

  // Comparator judges the registered trial code on this same clock, so it
  // is read directly: a synchroniser would outlast a two-cycle bit period
  assign comp_level = COMP_IN;

  // Successive approximation: MSB trial loaded on entry, bits 9-0 decided at the ends of the first 10 periods, then one more period
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dac      <= 10'h000;
      conv_cnt <= 4'd0;
    end else if (next_state == adc_ctrl_pkg::ST_CONVERT &&
                 state != adc_ctrl_pkg::ST_CONVERT) begin
      dac      <= adc_ctrl_pkg::TRIAL_MSB;
      conv_cnt <= 4'd0;
    end else if (state == adc_ctrl_pkg::ST_CONVERT && bit_tick &&
                 conv_cnt != adc_ctrl_pkg::CONV_LAST) begin
      dac <= (comp_level ? dac : dac & ~(adc_ctrl_pkg::TRIAL_MSB >> conv_cnt))
             | (adc_ctrl_pkg::TRIAL_MSB >> (conv_cnt + 4'd1));
      conv_cnt <= conv_cnt + 4'd1;
    end
  end

  // Result pair has no reset on purpose: it survives warm resets
  always_ff @(posedge CORE_CLK) begin
    if (finish) begin
      if (result_justify) begin
        result_high <= {6'h00, dac[9:8]};
        result_low  <= dac[7:0];
      end else begin
        result_high <= dac[9:2];
        result_low  <= {dac[1:0], 6'h00};
      end
    end
  end

  // Done flag: a finish in the clearing cycle wins over the clear
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N)
      done_flag <= 1'b0;
    else if (finish)
      done_flag <= 1'b1;
    else if (wr_pend && wr_addr == adc_ctrl_pkg::STAT_ADDR &&
             HWDATA[adc_ctrl_pkg::DONE_BIT])
      done_flag <= 1'b0;
  end

  // Registered front-end controls
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ANALOG_MUX    <= 13'h0000;
      ANALOG_MAP    <= 13'h0000;
      SAMPLE_ENABLE <= 1'b0;
    end else begin
      for (int i = 0; i < adc_ctrl_pkg::NUM_CHANNELS; i++) begin
        ANALOG_MUX[i] <= converter_on && (channel_select == 4'(i));
        ANALOG_MAP[i] <= (port_analog_map < adc_ctrl_pkg::MAP_FIRST_DIG) ||
                         (5'(i) < 5'd15 - 5'(port_analog_map));
      end
      SAMPLE_ENABLE <= converter_on &&
                       next_state != adc_ctrl_pkg::ST_CONVERT;
    end
  end

  assign NEG_REF_SELECT       = neg_ref_select;
  assign POS_REF_SELECT       = pos_ref_select;
  assign DAC_CODE             = dac;
  assign CONVERTER_ON         = converter_on;
  assign CONVERSION_DONE_FLAG = done_flag;

  // Checks
  property p_start_busy;
    start |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("go did not start a conversion");
  property p_finish_done;
    finish |=> !busy && done_flag;
  endproperty
  a_finish_done: assert property (p_finish_done)
    else $error("finish did not clear go and set flag");
  property p_off_idle;
    !converter_on |=> !busy;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("converter off but still busy");
  property p_zero_acq;
    start && !rc_sel && acquire_time_select == 3'h0
      |=> state == adc_ctrl_pkg::ST_CONVERT;
  endproperty
  a_zero_acq: assert property (p_zero_acq)
    else $error("zero acquisition did not convert at once");
  property p_rc_delay;
    start && rc_sel |=> (state == adc_ctrl_pkg::ST_RC_DELAY) [*4];
  endproperty
  a_rc_delay: assert property (p_rc_delay)
    else $error("RC start delay wrong length");
  property p_acq_end;
    state == adc_ctrl_pkg::ST_ACQUIRE ##1 state == adc_ctrl_pkg::ST_CONVERT
      |-> $past(acq_left) == 5'd1;
  endproperty
  a_acq_end: assert property (p_acq_end)
    else $error("conversion began before acquisition ended");
  property p_conv_len;
    finish |-> conv_cnt == 4'd10 && state == adc_ctrl_pkg::ST_CONVERT;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length is not eleven periods");
  property p_sleep_hold;
    SLEEP && !rc_sel && busy |=> $stable(dac) && $stable(tick_cnt);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("conversion advanced in sleep on oscillator clock");
  // The release edge itself still sees reset, so it loads nothing yet
  property p_strap;
    RST_N && !strap_done |=> port_analog_map ==
      ($past(PORTB_ANALOG_DEFAULT) ? 4'h0 : 4'h7);
  endproperty
  a_strap: assert property (p_strap)
    else $error("port map strap load wrong");
  property p_unimpl_zero;
    addr_ok && !HWRITE && HADDR[7:0] == adc_ctrl_pkg::CTRL0_ADDR
      |=> HRDATA[7:6] == 2'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bits read nonzero");
  property p_justify;
    finish && result_justify |=> result_high[7:2] == 6'h00;
  endproperty
  a_justify: assert property (p_justify)
    else $error("right justified result has high bits set");
endmodule // sar_adc_control

//--- dv/analog_front_model.sv
// Analog front end stand-in: pin levels, hold capacitor, comparator
`timescale 1ns/100ps
module analog_front_model (
  // Converter side
  input  wire logic        clk,
  input  wire logic [12:0] mux,
  input  wire logic        sample,
  input  wire logic [9:0]  dac,
  // Comparator decision
  output logic             comp
);
  logic [9:0] level [13];
  logic [9:0] held  = 10'h0;
  logic [9:0] drift = 10'h155;

  // Capacitor follows the selected pin only while the switch is closed;
  // an unselected input floats, so it wanders rather than holding still
  always @(posedge clk) begin
    drift <= ~drift + 10'h3;
    if (sample) begin
      held <= drift;
      for (int k = 0; k < 13; k++) begin
        if (mux[k]) begin
          held <= level[k];
        end
      end
    end
  end

  // Ideal comparator, high when the held level reaches the trial code
  assign comp = (held >= dac);
endmodule // analog_front_model

//--- dv/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] A_CTL  = adc_ctrl_pkg::CTRL0_ADDR;
  localparam logic [7:0] A_CFG1 = adc_ctrl_pkg::CFG1_ADDR;
  localparam logic [7:0] A_CFG2 = adc_ctrl_pkg::CFG2_ADDR;
  localparam logic [7:0] A_RH   = adc_ctrl_pkg::RESH_ADDR;
  localparam logic [7:0] A_RL   = adc_ctrl_pkg::RESL_ADDR;
  localparam logic [7:0] A_ST   = adc_ctrl_pkg::STAT_ADDR;
  localparam int         RC     = adc_ctrl_pkg::RC_TAD_CYCLES;
  // Bench-driven inputs
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        sleep = 1'b0, strap = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  // Design outputs
  logic [31:0] hrdata;
  logic [1:0]  hresp;
  logic [12:0] mux, map;
  logic [9:0]  dac;
  logic        hreadyout, comp, nref, pref, sample, on, flag;
  // Bench state
  int          bad_count = 0;
  int          checks = 0;
  int          per [8];
  int          acq [8];
  logic [31:0] r;
  logic [3:0]  ch;
  logic [9:0]  v;
  logic [7:0]  res_h, res_l;
  logic [1:0]  b;

  sar_adc_control sar_adc_control_i (
    .CORE_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .SLEEP(sleep), .PORTB_ANALOG_DEFAULT(strap),
    .COMP_IN(comp), .ANALOG_MUX(mux), .ANALOG_MAP(map),
    .NEG_REF_SELECT(nref), .POS_REF_SELECT(pref),
    .SAMPLE_ENABLE(sample), .DAC_CODE(dac), .CONVERTER_ON(on),
    .CONVERSION_DONE_FLAG(flag));

  analog_front_model analog_front_model_i (
    .clk(clk), .mux(mux), .sample(sample), .dac(dac), .comp(comp));

  // 25 MHz core clock
  always #20 clk = ~clk;

  // Analog inputs left after a port map code
  function automatic logic [12:0] map_exp(input int code);
    return code < 3 ? 13'h1FFF : 13'h1FFF >> (code - 2);
  endfunction

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One single transfer; each phase waits on ready, bounded
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] wd);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
        bad_count++;
        stop_test();
      end
      if (ph == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
      end
    end
    r = hrdata;
    chk("response", 32'(adc_ctrl_pkg::HRESP_OKAY), 32'(hresp));
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                      input string w);
    bus(1'b0, a, 8'h0);
    chk(w, {24'h0, e}, r);
  endtask

  // Configure, switch on, then set go in a later write
  task automatic start(input logic [2:0] cs, input logic [2:0] aq,
                       input logic just);
    ch = 4'($urandom_range(12));
    v = 10'($urandom);
    analog_front_model_i.level[ch] = v;
    bus(1'b1, A_CFG2, {just, 1'b0, aq, cs});
    bus(1'b1, A_CTL, {2'h0, ch, 2'h1});
    // Let the closed switch take the new channel before go
    repeat (4) @(posedge clk);
    bus(1'b1, A_CTL, {2'h0, ch, 2'h3});
  endtask

  // Full conversion; nap sleeps the core that many cycles on a divider clock, until done on the RC clock
  task automatic convert(input logic [2:0] cs, input logic [2:0] aq,
                         input logic just, input int nap);
    int p;
    int e;
    int n;
    p = per[cs];
    e = acq[aq] * p + 11 * p;
    if (cs[1:0] == 2'h3)
      e += adc_ctrl_pkg::INSTR_CYCLES;
    start(cs, aq, just);
    rchk(A_CTL, {2'h0, ch, 2'h3}, "busy");
    if (cs[1:0] != 2'h3)
      chk("sampling", 32'(aq != 3'h0), 32'(sample));
    n = 2;
    if (nap > 0) begin
      sleep <= 1'b1;
      repeat (nap) @(posedge clk);
      n += nap;
      // A divider clock stops while asleep, the RC clock does not
      if (cs[1:0] != 2'h3) begin
        chk("frozen", 32'h0, 32'(flag));
        sleep <= 1'b0;
        e += nap;
      end
    end
    while (flag !== 1'b1 && n < e + p + 8) begin
      @(posedge clk);
      n++;
    end
    sleep <= 1'b0;
    chk("latency", 32'h1, 32'(n >= e - p && n <= e + 8));
    chk("latency cs", 32'h1, 32'(n >= e - p));
    if (flag !== 1'b1)
      stop_test();
    chk("dac code", {22'h0, v}, {22'h0, dac});
    rchk(A_CTL, {2'h0, ch, 2'h1}, "go cleared");
    res_h = just ? {6'h0, v[9:8]} : v[9:2];
    res_l = just ? v[7:0] : {v[1:0], 6'h0};
    rchk(A_RH, res_h, "result high");
    rchk(A_RL, res_l, "result low");
    chk("resample", 32'h1, 32'(sample));
    rchk(A_ST, 8'h1, "done flag");
    bus(1'b1, A_ST, 8'h1);
    rchk(A_ST, 8'h0, "flag cleared");
    repeat (3 * p) @(posedge clk);
  endtask

  initial begin
    void'($urandom(33973));
    per = '{2, 8, 32, RC, 4, 16, 64, RC};
    acq = '{0, 2, 4, 6, 8, 12, 16, 20};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state, unmapped space and unused bits
    rchk(A_CTL, 8'h0, "ctrl reset");
    rchk(A_CFG1, 8'h0, "cfg1 reset");
    rchk(A_CFG2, 8'h0, "cfg2 reset");
    chk("map reset", 32'(map_exp(0)), 32'(map));
    bus(1'b1, 8'h18, 8'hFF);
    rchk(8'h18, 8'h0, "unmapped");
    bus(1'b1, A_CTL, 8'hC2);
    rchk(A_CTL, 8'h0, "go while off");
    bus(1'b1, A_CFG2, 8'hFF);
    rchk(A_CFG2, 8'hBF, "cfg2 unused");
    // Every port map code with random reference choices
    for (int i = 0; i < 16; i++) begin
      b = 2'($urandom);
      bus(1'b1, A_CFG1, {2'h3, b, i[3:0]});
      rchk(A_CFG1, {2'h0, b, i[3:0]}, "cfg1");
      chk("map", 32'(map_exp(i)), 32'(map));
      chk("refs", {30'h0, b}, {30'h0, nref, pref});
    end
    bus(1'b1, A_CFG1, 8'h0);
    // Every channel code, then off
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, A_CTL, {2'h0, i[3:0], 2'h1});
      repeat (2) @(posedge clk);
      chk("mux", 32'(i < 13 ? 13'h1 << i : 13'h0), 32'(mux));
      chk("on", 32'h1, 32'(on));
    end
    bus(1'b1, A_CTL, 8'h14);
    repeat (2) @(posedge clk);
    chk("off", 32'h0, {18'h0, mux, on});
    // Every clock and acquisition code, then random ones
    for (int i = 0; i < 8; i++) begin
      convert(i[2:0], 3'(7 - i), i[0], i % 3 == 0 ? 40 : 0);
    end
    repeat (4) convert(3'($urandom), 3'($urandom), 1'($urandom), 0);
    // Switching off mid-conversion abandons it
    start(3'h6, 3'h7, 1'b1);
    repeat (100) @(posedge clk);
    bus(1'b1, A_CTL, {2'h0, ch, 2'h0});
    repeat (2500) @(posedge clk);
    chk("abort", 32'h0, 32'(flag));
    // Reset mid-conversion with the strap low
    start(3'h6, 3'h2, 1'b0);
    strap <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(A_CTL, 8'h0, "ctrl after reset");
    rchk(A_CFG1, 8'h7, "cfg1 strap low");
    chk("map strap low", 32'(map_exp(7)), 32'(map));
    rchk(A_RH, res_h, "kept high");
    rchk(A_RL, res_l, "kept low");
    repeat (2500) @(posedge clk);
    chk("no result", 32'h0, 32'(flag));
    stop_test();
  end
endmodule // tb
